// ===== shared/pcrb_defs.vh
`ifndef PCRB_DEFS_VH
`define PCRB_DEFS_VH
`define PCRB_OFS_ID_RBADDR 5'h00
`define PCRB_OFS_ENABLE 5'h01
`define PCRB_OFS_REFERENCE_DIVIDER 5'h02
`define PCRB_OFS_INTDIV 5'h03
`define PCRB_OFS_FRACDIV 5'h04
`define PCRB_RST_ENABLE 24'h000003
`define PCRB_RST_REFERENCE_DIVIDER 24'h000001
`define PCRB_RST_INTDIV 24'h000019
`define PCRB_RST_FRACDIV 24'h000000
`define PCRB_RST_RBADDR 5'h00
`define PCRB_RST_REF_RATIO 14'h0001
`define PCRB_RST_INT_RATIO 19'h00019
`define PCRB_CHIP_ADDR 3'h0
`define PCRB_FRAME_BITS 6'h20
`define PCRB_DATA_W 24
`define PCRB_BIT_PIN_SEL 0
`define PCRB_BIT_SPI_EN 1
`define PCRB_BIT_KEEP_BIAS 2
`define PCRB_BIT_KEEP_PFD 3
`define PCRB_BIT_KEEP_CP 4
`define PCRB_BIT_KEEP_REF 5
`define PCRB_BIT_KEEP_VCOBUF 6
`define PCRB_BIT_KEEP_GPO 7
`define PCRB_BIT_SOFT_RST 5
`define PCRB_REFERENCE_DIVIDER_W 14
`define PCRB_INTDIV_W 19
`endif

// ===== hw/pcrb_pin_sync.v
`timescale 1ns/10ps
`default_nettype none
// *****************************************************************
// Three-stage pin synchroniser with agreement filter
// *****************************************************************
module pcrb_pin_sync
(
  input wire core_clk,
  input wire rst,
  input wire pin,
  output reg level
);
  reg s1;
  reg s2;
  reg s3;
  // Only s2 reads s1; the output moves once s2 and s3 agree.
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level <= s3;
    end
  end
endmodule // pcrb_pin_sync
`default_nettype wire

// ===== hw/pcrb_register_bank.v
// What this block does
// - Readback runs without strobe; strobe rise restores lock-detect output.
// - Offset 00h reads a fixed 24-bit identity; writes never change it.
// - Write to 00h captures bits 4:0 as next readback address.
// - Bit 5 of a 00h write is a soft-reset strobe; host keeps it zero.
// - Enable select bit 1 follows enable pin; pin low powers down.
// - Enable select bit 0 ignores pin; bit 1 of 01h enables.
// - Keep-on bits 2,3,4 hold bias, detector, charge pump powered.
// - Bits 5,6,7 force reference buffer, VCO buffer, output driver on.
// - Offset 02h holds 14-bit reference ratio, reset 1.
// - Offset 03h holds 19-bit integer divider, reset 25.
// - Offset 04h holds 24-bit fraction, reset zero, value over 2^24.
// - Fraction applies only in fractional mode; integer mode ignores it.
// - Frame is 24 data, 5 address, 3 chip bits, MSB first.
// - Strobe rise after 32 bits loads register when chip address is zero.
// - Each frame shifts out the register chosen by the readback address.
`timescale 1ns/10ps
`default_nettype none
`include "pcrb_defs.vh"
module pcrb_register_bank
#(
  parameter [23:0] DEVICE_IDENTITY = 24'h5a5a01 // Value is arbitrary.
)
(
  input wire core_clk,
  input wire rst,
  input wire serial_clock,
  input wire serial_data_in,
  input wire serial_frame_strobe,
  input wire chip_enable_pin,
  input wire lock_detect,
  input wire fractional_mode,
  output reg lock_detect_serial_out,
  output reg serial_out_active,
  output reg bias_on,
  output reg phase_frequency_detector_on,
  output reg charge_pump_on,
  output reg reference_buffer_on,
  output reg vco_buffer_on,
  output reg general_purpose_output_on,
  output reg chip_enabled,
  output reg [13:0] reference_ratio,
  output reg [18:0] integer_ratio,
  output reg [23:0] fraction_word
);
  // *****************************************************************
  // Pin synchronisers and edge detection
  // *****************************************************************
  wire sclk_s;
  wire sdi_s;
  wire sen_s;
  wire cen_s;
  reg sclk_d;
  reg sen_d;
  pcrb_pin_sync u_sclk (.core_clk(core_clk), .rst(rst),
    .pin(serial_clock), .level(sclk_s));
  pcrb_pin_sync u_sdi (.core_clk(core_clk), .rst(rst),
    .pin(serial_data_in), .level(sdi_s));
  pcrb_pin_sync u_sen (.core_clk(core_clk), .rst(rst),
    .pin(serial_frame_strobe), .level(sen_s));
  pcrb_pin_sync u_cen (.core_clk(core_clk), .rst(rst),
    .pin(chip_enable_pin), .level(cen_s));
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire sen_rise = sen_s & ~sen_d;

  // *****************************************************************
  // Registers
  // *****************************************************************
  reg [31:0] shifter;
  reg [5:0] bit_count;
  reg [23:0] enable_reg;
  reg [23:0] reference_divider_reg;
  reg [23:0] intdiv_reg;
  reg [23:0] fracdiv_reg;
  reg [4:0] readback_addr;
  reg [23:0] read_word;
  reg reading;

  // Unmapped readback addresses return zero.
  function [23:0] reg_value;
    input [4:0] addr;
    begin
      if (addr == `PCRB_OFS_ID_RBADDR)
        reg_value = DEVICE_IDENTITY;
      else if (addr == `PCRB_OFS_ENABLE)
        reg_value = enable_reg;
      else if (addr == `PCRB_OFS_REFERENCE_DIVIDER)
        reg_value = reference_divider_reg;
      else if (addr == `PCRB_OFS_INTDIV)
        reg_value = intdiv_reg;
      else if (addr == `PCRB_OFS_FRACDIV)
        reg_value = fracdiv_reg;
      else
        reg_value = 24'h000000;
    end
  endfunction

  wire [23:0] wr_data = shifter[31:8];
  wire [4:0] wr_addr = shifter[7:3];
  wire [2:0] wr_chip = shifter[2:0];
  wire frame_done = (bit_count == `PCRB_FRAME_BITS);
  wire load = sen_rise & frame_done & (wr_chip == `PCRB_CHIP_ADDR);
  wire soft_rst = load & (wr_addr == `PCRB_OFS_ID_RBADDR) &
    wr_data[`PCRB_BIT_SOFT_RST];

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_d <= 1'b0;
      sen_d <= 1'b0;
      shifter <= 32'h00000000;
      bit_count <= 6'h00;
      enable_reg <= `PCRB_RST_ENABLE;
      reference_divider_reg <= `PCRB_RST_REFERENCE_DIVIDER;
      intdiv_reg <= `PCRB_RST_INTDIV;
      fracdiv_reg <= `PCRB_RST_FRACDIV;
      readback_addr <= `PCRB_RST_RBADDR;
    end
    else
    begin
      sclk_d <= sclk_s;
      sen_d <= sen_s;
      if (sen_rise)
        bit_count <= 6'h00;
      else if (sclk_rise && !sen_s)
      begin
        shifter <= {shifter[30:0], sdi_s};
        if (!frame_done)
          bit_count <= bit_count + 6'h01;
      end
      if (soft_rst)
      begin
        enable_reg <= `PCRB_RST_ENABLE;
        reference_divider_reg <= `PCRB_RST_REFERENCE_DIVIDER;
        intdiv_reg <= `PCRB_RST_INTDIV;
        fracdiv_reg <= `PCRB_RST_FRACDIV;
        readback_addr <= `PCRB_RST_RBADDR;
      end
      else if (load)
      begin
        if (wr_addr == `PCRB_OFS_ID_RBADDR)
          readback_addr <= wr_data[4:0];
        else if (wr_addr == `PCRB_OFS_ENABLE)
          enable_reg <= wr_data;
        else if (wr_addr == `PCRB_OFS_REFERENCE_DIVIDER)
          reference_divider_reg <= wr_data;
        else if (wr_addr == `PCRB_OFS_INTDIV)
          intdiv_reg <= wr_data;
        else if (wr_addr == `PCRB_OFS_FRACDIV)
          fracdiv_reg <= wr_data;
      end
    end
  end

  // *****************************************************************
  // Readback shifter
  // *****************************************************************
  // The word is latched at the first rising edge of a frame and moved on
  // each falling edge, so the host sees bit 23 after the first rise.
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      read_word <= 24'h000000;
      reading <= 1'b0;
      lock_detect_serial_out <= 1'b0;
      serial_out_active <= 1'b0;
    end
    else
    begin
      if (sen_rise)
        reading <= 1'b0;
      else if (sclk_rise && !sen_s && bit_count == 6'h00)
      begin
        reading <= 1'b1;
        read_word <= reg_value(readback_addr);
      end
      else if (sclk_fall && reading)
        read_word <= {read_word[22:0], 1'b0};
      serial_out_active <= reading;
      lock_detect_serial_out <= reading ? read_word[23] : lock_detect;
    end
  end

  // *****************************************************************
  // Power and divider outputs
  // *****************************************************************
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      chip_enabled <= 1'b0;
      bias_on <= 1'b0;
      phase_frequency_detector_on <= 1'b0;
      charge_pump_on <= 1'b0;
      reference_buffer_on <= 1'b0;
      vco_buffer_on <= 1'b0;
      general_purpose_output_on <= 1'b0;
      reference_ratio <= `PCRB_RST_REF_RATIO;
      integer_ratio <= `PCRB_RST_INT_RATIO;
      fraction_word <= `PCRB_RST_FRACDIV;
    end
    else
    begin
      chip_enabled <= enable_reg[`PCRB_BIT_PIN_SEL] ? cen_s
        : enable_reg[`PCRB_BIT_SPI_EN];
      bias_on <= chip_enabled | enable_reg[`PCRB_BIT_KEEP_BIAS];
      phase_frequency_detector_on <= chip_enabled |
        enable_reg[`PCRB_BIT_KEEP_PFD];
      charge_pump_on <= chip_enabled | enable_reg[`PCRB_BIT_KEEP_CP];
      reference_buffer_on <= chip_enabled |
        enable_reg[`PCRB_BIT_KEEP_REF];
      vco_buffer_on <= chip_enabled |
        enable_reg[`PCRB_BIT_KEEP_VCOBUF];
      general_purpose_output_on <= chip_enabled |
        enable_reg[`PCRB_BIT_KEEP_GPO];
      reference_ratio <= reference_divider_reg[`PCRB_REFERENCE_DIVIDER_W-1:0];
      integer_ratio <= intdiv_reg[`PCRB_INTDIV_W-1:0];
      fraction_word <= fractional_mode ? fracdiv_reg : 24'h000000;
    end
  end
endmodule // pcrb_register_bank
`default_nettype wire

// ===== bench/pcrb_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pcrb_checker
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serial_frame_strobe,
  input wire logic chip_enable_pin,
  input wire logic lock_detect,
  input wire logic fractional_mode,
  input wire logic lock_detect_serial_out,
  input wire logic serial_out_active,
  input wire logic bias_on,
  input wire logic general_purpose_output_on,
  input wire logic chip_enabled,
  input wire logic [13:0] reference_ratio,
  input wire logic [18:0] integer_ratio,
  input wire logic [23:0] fraction_word
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  chk_frac_gated:
    assert property (!fractional_mode [*3] |=> fraction_word == 24'h0)
    else $error("fraction not cleared in integer mode");
  chk_idle_lock:
    assert property (!$past(rst) && !serial_out_active &&
      !$past(serial_out_active) |->
      lock_detect_serial_out == $past(lock_detect))
    else $error("idle line does not show lock detect");
  chk_strobe_ends:
    assert property (serial_frame_strobe [*8] |-> !serial_out_active)
    else $error("readback still shown after strobe");
  chk_keep_follow:
    assert property (chip_enabled |=> bias_on && general_purpose_output_on)
    else $error("block off while chip enabled");
  chk_ratio_hold:
    assert property (!serial_frame_strobe [*8] |=>
      $stable(reference_ratio) && $stable(integer_ratio))
    else $error("divider changed without strobe");
  chk_read_start:
    assert property ($rose(serial_out_active) |-> !serial_frame_strobe)
    else $error("readback started with strobe high");
  chk_frac_hold:
    assert property ((!serial_frame_strobe && fractional_mode) [*8] |=>
      $stable(fraction_word))
    else $error("fraction changed without strobe");
  chk_enable_hold:
    assert property ((!serial_frame_strobe && $stable(chip_enable_pin)) [*8]
      |=> $stable(chip_enabled))
    else $error("chip enable changed without cause");
  cover property ($rose(serial_out_active));
  cover property ($fell(chip_enabled));
  cover property (fraction_word != 24'h0);
endmodule // pcrb_checker
bind pcrb_register_bank pcrb_checker chk (.*);
`default_nettype wire

// ===== bench/pcrb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pcrb_host_model
(
  input wire logic core_clk,
  input wire logic lock_detect_serial_out,
  output var logic serial_clock,
  output var logic serial_data_in,
  output var logic serial_frame_strobe
);
  initial
  begin
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
    serial_frame_strobe = 1'b1;
  end
  // Readback is taken late in the low phase, clear of both bit changes.
  task automatic xfer(input logic [31:0] w, output logic [23:0] rd);
    rd = 24'h0;
    serial_frame_strobe = 1'b0;
    serial_data_in = w[31];
    repeat (4) @(negedge core_clk);
    for (int i = 31; i >= 0; i--)
    begin
      serial_clock = 1'b1;
      repeat (4) @(negedge core_clk);
      serial_clock = 1'b0;
      @(negedge core_clk);
      if (i > 0)
        serial_data_in = w[i-1];
      repeat (2) @(negedge core_clk);
      if (i >= 8)
        rd[i-8] = lock_detect_serial_out;
      @(negedge core_clk);
    end
    serial_data_in = ~serial_data_in;
    serial_frame_strobe = 1'b1;
    repeat (10) @(negedge core_clk);
  endtask
endmodule // pcrb_host_model
`default_nettype wire

// ===== bench/pll_control_register_bank_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module pll_control_register_bank_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic chip_enable_pin = 1'b0;
  logic lock_detect = 1'b0;
  logic fractional_mode = 1'b1;
  logic serial_clock, serial_data_in, serial_frame_strobe;
  logic lock_detect_serial_out, serial_out_active, chip_enabled;
  logic bias_on, phase_frequency_detector_on, charge_pump_on;
  logic reference_buffer_on, vco_buffer_on, general_purpose_output_on;
  logic [13:0] reference_ratio;
  logic [18:0] integer_ratio;
  logic [23:0] fraction_word, rd;
  localparam logic [23:0] ID_WORD = 24'h3c96e1; // Value is arbitrary.
  int n_mismatch = 0;
  int n_checks = 0;
  wire [5:0] keep_on = {general_purpose_output_on, vco_buffer_on,
    reference_buffer_on, charge_pump_on, phase_frequency_detector_on, bias_on};
  always #25 core_clk = ~core_clk;
  pcrb_register_bank #(.DEVICE_IDENTITY(ID_WORD)) dut (.*);
  pcrb_host_model host (.*);
  task automatic check(input string what, input logic [23:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    host.xfer({d, a, 3'h0}, rd);
  endtask
  task automatic t_reset;
    lock_detect = 1'b1;
    repeat (3) @(negedge core_clk);
    check("line", {serial_out_active, lock_detect_serial_out}, 24'h1);
    check("reference_divider", reference_ratio, 24'h1);
    check("intdiv", integer_ratio, 24'h19);
    check("pin off", chip_enabled, 24'h0);
    host.xfer({24'h0, 5'h02, 3'h1}, rd);
    check("id", rd, ID_WORD);
    check("other chip", reference_ratio, 24'h1);
  endtask
  task automatic t_regs;
    wr(5'h02, 24'hc03fff);
    check("reference_divider", reference_ratio, 24'h3fff);
    wr(5'h03, 24'hf80010);
    check("intdiv", integer_ratio, 24'h10);
    wr(5'h04, 24'habcdef);
    check("frac", fraction_word, 24'habcdef);
    fractional_mode = 1'b0;
    repeat (4) @(negedge core_clk);
    check("frac int", fraction_word, 24'h0);
    wr(5'h00, 24'h000002);
    wr(5'h00, 24'h000002);
    check("spare", rd, 24'hc03fff);
  endtask
  task automatic t_soft;
    // The address field asks for 02h; the soft reset must still leave
    // the readback pointing at the identity word.
    wr(5'h00, 24'h000022);
    check("pre soft", rd, 24'hc03fff);
    check("reference_divider", reference_ratio, 24'h1);
    check("intdiv", integer_ratio, 24'h19);
    wr(5'h00, 24'h0);
    check("id", rd, ID_WORD);
    check("line", {serial_out_active, lock_detect_serial_out}, 24'h1);
  endtask
  task automatic t_enable;
    chip_enable_pin = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      wr(5'h01, 24'h4 << k);
      check("keep", keep_on, 24'h1 << k);
      check("enabled", chip_enabled, 24'h0);
    end
    wr(5'h01, 24'h2);
    check("all on", keep_on, 24'h3f);
    wr(5'h01, 24'h1);
    check("pin on", chip_enabled, 24'h1);
    chip_enable_pin = 1'b0;
    repeat (10) @(negedge core_clk);
    check("pin off", keep_on, 24'h0);
  endtask
  initial
  begin
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    repeat (8) @(negedge core_clk);
    t_reset;
    t_regs;
    t_soft;
    t_enable;
    wrap_up;
  end
  initial
  begin
    #2000000;
    n_mismatch++;
    wrap_up;
  end
endmodule // pll_control_register_bank_tb_top
`default_nettype wire
